// File: rtl/hbdp_defines.vh
// Constants and timing counts for the half-bridge decode and protect block
`ifndef HBDP_DEFINES_VH
`define HBDP_DEFINES_VH
`define HBDP_CLK_MHZ 20
`define HBDP_SCH_SIX 2'h0
`define HBDP_SCH_SIX_LIM 2'h1
`define HBDP_SCH_THREE 2'h2
`define HBDP_SCH_THREE_LIM 2'h3
`define HBDP_OUT_OFF 2'h0
`define HBDP_OUT_HIGH 2'h1
`define HBDP_OUT_LOW 2'h2
// Times in ns or ms, counts in cycles (qualify: round up)
`define HBDP_T_OCF0_NS 300
`define HBDP_T_OCF1_NS 600
`define HBDP_T_OCF2_NS 1250
`define HBDP_T_OCF3_NS 1600
`define HBDP_T_UV_NS 5000
`define HBDP_T_OV_NS 5000
`define HBDP_T_BLANK_NS 5000
`define HBDP_T_RST_SHORT_MS 5
`define HBDP_T_RST_LONG_MS 500
`define HBDP_T_READY_MS 1
`define HBDP_CYC_NS(t) (((t) * `HBDP_CLK_MHZ + 999) / 1000)
`define HBDP_CYC_MS(t) ((t) * `HBDP_CLK_MHZ * 1000)
`define HBDP_CYC_OCF0 `HBDP_CYC_NS(`HBDP_T_OCF0_NS)
`define HBDP_CYC_OCF1 `HBDP_CYC_NS(`HBDP_T_OCF1_NS)
`define HBDP_CYC_OCF2 `HBDP_CYC_NS(`HBDP_T_OCF2_NS)
`define HBDP_CYC_OCF3 `HBDP_CYC_NS(`HBDP_T_OCF3_NS)
`define HBDP_CYC_UV `HBDP_CYC_NS(`HBDP_T_UV_NS)
`define HBDP_CYC_OV `HBDP_CYC_NS(`HBDP_T_OV_NS)
`define HBDP_CYC_BLANK `HBDP_CYC_NS(`HBDP_T_BLANK_NS)
`define HBDP_CYC_RST_SHORT `HBDP_CYC_MS(`HBDP_T_RST_SHORT_MS)
`define HBDP_CYC_RST_LONG `HBDP_CYC_MS(`HBDP_T_RST_LONG_MS)
`define HBDP_CYC_READY `HBDP_CYC_MS(`HBDP_T_READY_MS)
`endif

// File: rtl/hbdp_deglitch.v
// Persistence filter: output follows input after it holds for a set count
`timescale 1ns/1ps
module hbdp_deglitch (
    input wire mclk,
    input wire rst_n,
    input wire raw,
    input wire [7:0] count_lim,
    output reg qual
);
    reg [7:0] cnt_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            qual <= 1'b0;
        end else if (raw == qual) begin
            cnt_q <= 8'h00;
        end else if (cnt_q >= count_lim - 8'h01) begin
            cnt_q <= 8'h00;
            qual <= raw;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// File: rtl/hbdp_top.v
// Half-bridge input decode, current limit and fault qualification
`timescale 1ns/1ps
`include "hbdp_defines.vh"
module hbdp_top #(
    parameter RST_SHORT_CYC = `HBDP_CYC_RST_SHORT,
    parameter RST_LONG_CYC = `HBDP_CYC_RST_LONG,
    parameter READY_CYC = `HBDP_CYC_READY
) (
    input wire mclk,
    input wire resetn,
    input wire [2:0] high_side_input,
    input wire [2:0] low_side_input,
    input wire [1:0] scheme_select,
    input wire strap_variant,
    input wire [1:0] overcurrent_filter_select,
    input wire overcurrent_restart_select,
    input wire overcurrent_trip_level,
    input wire supply_high_guard_enable,
    input wire supply_high_guard_threshold,
    input wire [2:0] overcurrent_raw,
    input wire supply_low_raw,
    input wire supply_high_raw,
    input wire limit_compare_raw,
    output reg [5:0] half_bridge_output,
    output reg reference_or_limit_input,
    output reg sense_amp_output,
    output reg trip_level_high,
    output reg supply_high_level_low,
    output reg fault_flag_n_o,
    output reg fault_flag_n_oe,
    output reg [3:0] fault_status,
    output reg serial_ready
);
    localparam ST_RUN = 2'h0;
    localparam ST_HOLD = 2'h1;
    localparam ST_WAIT = 2'h2;
    // Cycle counts as full 32-bit values
    localparam [31:0] OCF0_W = `HBDP_CYC_OCF0;
    localparam [31:0] OCF1_W = `HBDP_CYC_OCF1;
    localparam [31:0] OCF2_W = `HBDP_CYC_OCF2;
    localparam [31:0] OCF3_W = `HBDP_CYC_OCF3;
    localparam [31:0] UV_W = `HBDP_CYC_UV;
    localparam [31:0] OV_W = `HBDP_CYC_OV;
    localparam [31:0] BLANK_W = `HBDP_CYC_BLANK;
    localparam [31:0] RST_S_W = RST_SHORT_CYC;
    localparam [31:0] RST_L_W = RST_LONG_CYC;
    localparam [31:0] RDY_W = READY_CYC;
    // Counts cut to their counter widths
    localparam [7:0] OCF0 = OCF0_W[7:0];
    localparam [7:0] OCF1 = OCF1_W[7:0];
    localparam [7:0] OCF2 = OCF2_W[7:0];
    localparam [7:0] OCF3 = OCF3_W[7:0];
    localparam [7:0] UV_CYC = UV_W[7:0];
    localparam [7:0] OV_CYC = OV_W[7:0];
    localparam [7:0] BLANK_CYC = BLANK_W[7:0];
    localparam [23:0] RST_S = RST_S_W[23:0];
    localparam [23:0] RST_L = RST_L_W[23:0];
    localparam [15:0] RDY = RDY_W[15:0];

    reg rst_s1_q;
    reg rst_n;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // Per-phase decode of one input pair
    function [1:0] decode_phase;
        input [1:0] scheme;
        input hi;
        input lo;
        begin
            if (scheme[1]) begin
                if (!lo)
                    decode_phase = `HBDP_OUT_OFF;
                else
                    decode_phase = hi ? `HBDP_OUT_HIGH : `HBDP_OUT_LOW;
            end else begin
                case ({lo, hi})
                    2'b01: decode_phase = `HBDP_OUT_HIGH;
                    2'b10: decode_phase = `HBDP_OUT_LOW;
                    default: decode_phase = `HBDP_OUT_OFF;
                endcase
            end
        end
    endfunction

    // Scheme carries a current limit
    function is_limited;
        input [1:0] scheme;
        begin
            is_limited = (scheme == `HBDP_SCH_SIX_LIM) ||
                (scheme == `HBDP_SCH_THREE_LIM);
        end
    endfunction

    // Overcurrent filter length
    reg [7:0] ocf_lim;
    always @* begin
        if (strap_variant) begin
            ocf_lim = OCF0;
        end else begin
            case (overcurrent_filter_select)
                2'h0: ocf_lim = OCF0;
                2'h1: ocf_lim = OCF1;
                2'h2: ocf_lim = OCF2;
                default: ocf_lim = OCF3;
            endcase
        end
    end

    wire oc_any = |overcurrent_raw;
    wire oc_qual;
    wire uv_qual;
    wire ov_qual;
    wire ov_gated = supply_high_raw & supply_high_guard_enable & ~strap_variant;

    hbdp_deglitch u_oc (
        .mclk(mclk),
        .rst_n(rst_n),
        .raw(oc_any),
        .count_lim(ocf_lim),
        .qual(oc_qual)
    );
    hbdp_deglitch u_uv (
        .mclk(mclk),
        .rst_n(rst_n),
        .raw(supply_low_raw),
        .count_lim(UV_CYC),
        .qual(uv_qual)
    );
    hbdp_deglitch u_ov (
        .mclk(mclk),
        .rst_n(rst_n),
        .raw(ov_gated),
        .count_lim(OV_CYC),
        .qual(ov_qual)
    );

    // Overcurrent restart sequence
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [23:0] rcnt_q;
    reg [23:0] rcnt_d;
    wire [23:0] rst_lim = (!strap_variant && overcurrent_restart_select) ? RST_L : RST_S;
    always @* begin
        st_d = st_q;
        rcnt_d = rcnt_q;
        case (st_q)
            ST_RUN: begin
                if (oc_qual) begin
                    st_d = ST_HOLD;
                    rcnt_d = 24'h000000;
                end
            end
            ST_HOLD: begin
                if (rcnt_q >= rst_lim - 24'h000001) begin
                    st_d = ST_WAIT;
                end else begin
                    rcnt_d = rcnt_q + 24'h000001;
                end
            end
            ST_WAIT: begin
                if (!oc_qual)
                    st_d = ST_RUN;
                else begin
                    st_d = ST_HOLD;
                    rcnt_d = 24'h000000;
                end
            end
            default: st_d = ST_RUN;
        endcase
    end

    // Current limit blanking after switching
    reg [5:0] dec_prev_q;
    reg [7:0] blank_q;
    wire [5:0] dec;
    wire [5:0] masked;
    wire [2:0] ph_changed;
    wire lim_mode = is_limited(scheme_select);
    wire switched = (dec != dec_prev_q);
    // Comparator counts only outside blanking
    wire lim_hit = lim_mode && limit_compare_raw && (blank_q == 8'h00) && !switched;

    // Any decoded change restarts the blanking count
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dec_prev_q <= 6'h00;
            blank_q <= 8'h00;
        end else begin
            dec_prev_q <= dec;
            if (switched)
                blank_q <= BLANK_CYC - 8'h01;
            else if (blank_q != 8'h00)
                blank_q <= blank_q - 8'h01;
        end
    end

    // Per-phase decode, limit latch and high-side masking
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ph
            reg hs_block_q;
            reg [1:0] ph_d;
            // Decode of this phase
            assign dec[2*g+1:2*g] = decode_phase(scheme_select, high_side_input[g],
                low_side_input[g]);
            assign ph_changed[g] = (dec[2*g+1:2*g] != dec_prev_q[2*g+1:2*g]);
            // High side held off until this phase switches again or limit mode ends
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n)
                    hs_block_q <= 1'b0;
                else if (ph_changed[g] || !lim_mode)
                    hs_block_q <= 1'b0;
                else if (lim_hit)
                    hs_block_q <= 1'b1;
            end
            always @* begin
                ph_d = dec[2*g+1:2*g];
                if (hs_block_q && !ph_changed[g] && ph_d == `HBDP_OUT_HIGH)
                    ph_d = `HBDP_OUT_OFF;
            end
            assign masked[2*g+1:2*g] = ph_d;
        end
    endgenerate

    // Restart sequence registers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_RUN;
            rcnt_q <= 24'h000000;
        end else begin
            st_q <= st_d;
            rcnt_q <= rcnt_d;
        end
    end

    // Bridges forced off while overcurrent hold, undervoltage or overvoltage is active
    wire oc_hold = (st_d != ST_RUN);
    wire any_fault = oc_hold | uv_qual | ov_qual;
    reg [5:0] out_d;
    always @* begin
        out_d = masked;
        if (any_fault)
            out_d = 6'h00;
    end

    // Registered bridge drive
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            half_bridge_output <= 6'h00;
        else
            half_bridge_output <= out_d;
    end

    // Pin roles per scheme and configuration echo
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reference_or_limit_input <= 1'b0;
            sense_amp_output <= 1'b1;
            trip_level_high <= 1'b0;
            supply_high_level_low <= 1'b0;
        end else begin
            reference_or_limit_input <= lim_mode;
            sense_amp_output <= ~lim_mode;
            trip_level_high <= overcurrent_trip_level;
            supply_high_level_low <= supply_high_guard_threshold;
        end
    end

    // Open-drain fault flag and cause bits
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_flag_n_o <= 1'b0;
            fault_flag_n_oe <= 1'b0;
            fault_status <= 4'h0;
        end else begin
            fault_flag_n_o <= 1'b0;
            fault_flag_n_oe <= any_fault;
            if (!strap_variant)
                fault_status <= {ov_qual, uv_qual, oc_hold, any_fault};
            else
                fault_status <= 4'h0;
        end
    end

    // Serial port readiness after power up
    reg [15:0] rdy_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdy_q <= 16'h0000;
            serial_ready <= 1'b0;
        end else if (rdy_q >= RDY - 16'h0001) begin
            serial_ready <= 1'b1;
        end else begin
            rdy_q <= rdy_q + 16'h0001;
        end
    end
endmodule

// File: test/hbdp_props.sv
// Concurrent checks on the decode and protect top-level ports
`timescale 1ns/1ps
module hbdp_props #(
    parameter RST_SHORT_CYC = 50,
    parameter RST_LONG_CYC = 80
) (
    input wire mclk,
    input wire resetn,
    input wire [2:0] high_side_input,
    input wire [2:0] low_side_input,
    input wire [1:0] scheme_select,
    input wire strap_variant,
    input wire [1:0] overcurrent_filter_select,
    input wire overcurrent_restart_select,
    input wire overcurrent_trip_level,
    input wire supply_high_guard_enable,
    input wire supply_high_guard_threshold,
    input wire [2:0] overcurrent_raw,
    input wire supply_low_raw,
    input wire supply_high_raw,
    input wire [5:0] half_bridge_output,
    input wire reference_or_limit_input,
    input wire sense_amp_output,
    input wire trip_level_high,
    input wire supply_high_level_low,
    input wire fault_flag_n_o,
    input wire fault_flag_n_oe,
    input wire [3:0] fault_status
);
    logic [2:0] up_q;
    logic [7:0] uv_cnt_q, ov_cnt_q, oc_cnt_q;
    logic [31:0] hold_q;
    wire [23:0] oc_tab = {6'h20, 6'h19, 6'h0c, 6'h06};
    wire [5:0] oc_n = strap_variant ? 6'h06 : oc_tab[overcurrent_filter_select*6 +: 6];
    wire sel_long = overcurrent_restart_select && !strap_variant;
    wire [31:0] rc = sel_long ? RST_LONG_CYC : RST_SHORT_CYC;
    function automatic logic [1:0] dec(input logic [1:0] s, input logic h, input logic l);
        if (s[1]) return l ? (h ? 2'h1 : 2'h2) : 2'h0;
        return (h & !l) ? 2'h1 : ((l & !h) ? 2'h2 : 2'h0);
    endfunction
    // Consecutive-sample counters and settle counter after reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            up_q <= 3'h0;
            uv_cnt_q <= 8'h0;
            ov_cnt_q <= 8'h0;
            oc_cnt_q <= 8'h0;
            hold_q <= 32'h0;
        end else begin
            up_q <= (up_q == 3'h5) ? up_q : up_q + 3'h1;
            uv_cnt_q <= supply_low_raw ? uv_cnt_q + {7'h0, ~&uv_cnt_q} : 8'h0;
            ov_cnt_q <= (supply_high_raw && supply_high_guard_enable) ?
                ov_cnt_q + {7'h0, ~&ov_cnt_q} : 8'h0;
            oc_cnt_q <= (|overcurrent_raw) ? oc_cnt_q + {7'h0, ~&oc_cnt_q} : 8'h0;
            hold_q <= fault_status[1] ? hold_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn || up_q != 3'h5);
    sequence s_off2;
        half_bridge_output == 6'h0 ##1 half_bridge_output == 6'h0;
    endsequence
    chk_six_decode: assert property ($past(scheme_select) == 2'h0 && !fault_flag_n_oe
        && !$past(fault_flag_n_oe) |-> half_bridge_output[1:0] ==
        dec(2'h0, $past(high_side_input[0]), $past(low_side_input[0]))) else $error("six decode");
    chk_three_decode: assert property ($past(scheme_select) == 2'h2 && !fault_flag_n_oe
        && !$past(fault_flag_n_oe) |-> half_bridge_output[3:2] ==
        dec(2'h2, $past(high_side_input[1]), $past(low_side_input[1]))) else $error("three decode");
    chk_mode_pins: assert property ($stable(scheme_select) |->
        reference_or_limit_input == scheme_select[0] && sense_amp_output == !scheme_select[0])
        else $error("mode pins");
    chk_config_levels: assert property ($stable(overcurrent_trip_level) &&
        $stable(supply_high_guard_threshold) |-> trip_level_high == overcurrent_trip_level
        && supply_high_level_low == supply_high_guard_threshold) else $error("config levels");
    chk_uv_filter: assert property ($rose(fault_status[2]) |->
        uv_cnt_q >= 8'h63 && uv_cnt_q <= 8'h68) else $error("uv filter");
    chk_uv_off: assert property (uv_cnt_q >= 8'h6e |-> fault_flag_n_oe ##0 s_off2)
        else $error("uv not acted on");
    chk_ov_filter: assert property ($rose(fault_status[3]) |-> supply_high_guard_enable
        && ov_cnt_q >= 8'h63 && ov_cnt_q <= 8'h68) else $error("ov filter");
    chk_oc_filter: assert property ($rose(fault_status[1]) |-> oc_cnt_q + 8'h1 >= oc_n
        && oc_cnt_q <= oc_n + 6'h4 ##0 s_off2) else $error("oc filter");
    chk_oc_restart: assert property ($fell(fault_status[1]) |->
        $past(hold_q) + 32'h3 >= rc && $past(hold_q) <= rc + 32'h3) else $error("oc restart");
    chk_flag_any: assert property (fault_status[0] |-> fault_flag_n_oe && !fault_flag_n_o)
        else $error("fault flag");
endmodule
bind hbdp_top hbdp_props #(.RST_SHORT_CYC(RST_SHORT_CYC), .RST_LONG_CYC(RST_LONG_CYC)) i_props (.*);

// File: test/hbdp_ctrl_model.sv
// Controller model driving the per-phase inputs and scheme select
`timescale 1ns/1ps
module hbdp_ctrl_model (
    input wire mclk,
    input wire [2:0] want_hi,
    input wire [2:0] want_lo,
    input wire [1:0] want_sch,
    output reg [2:0] high_side_input = 3'h0,
    output reg [2:0] low_side_input = 3'h0,
    output reg [1:0] scheme_select = 2'h0
);
    always @(negedge mclk) begin
        if (want_sch != scheme_select && (high_side_input | low_side_input) != 3'h0) begin
            high_side_input <= 3'h0;
            low_side_input <= 3'h0;
        end else if (want_sch != scheme_select) begin
            scheme_select <= want_sch;
        end else begin
            high_side_input <= want_hi;
            low_side_input <= want_lo;
        end
    end
endmodule

// File: test/tb_hbdp_top.sv
// Self-checking bench for the half-bridge decode and protect block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("Error %0t: got %h expected %h", $time, a, b); end end
module tb_hbdp_top;
    logic mclk = 0, resetn = 0, strap_variant = 0, overcurrent_restart_select = 0;
    logic overcurrent_trip_level = 0, supply_high_guard_enable = 0, limit_compare_raw = 0;
    logic supply_high_guard_threshold = 0, supply_low_raw = 0, supply_high_raw = 0;
    logic [1:0] overcurrent_filter_select = 2'h0, want_sch = 2'h0, scheme_select;
    logic [2:0] overcurrent_raw = 3'h0, want_hi = 3'h0, want_lo = 3'h0;
    logic [2:0] high_side_input, low_side_input;
    logic [5:0] half_bridge_output;
    logic [3:0] fault_status;
    logic reference_or_limit_input, sense_amp_output, trip_level_high, supply_high_level_low;
    logic fault_flag_n_o, fault_flag_n_oe, serial_ready;
    int num_errors = 0, n_compared = 0;
    int ncyc[4] = '{6, 12, 25, 32}; // Qualification times at 50 ns
    hbdp_top #(.RST_SHORT_CYC(50), .RST_LONG_CYC(80), .READY_CYC(30)) i_dut (.*);
    hbdp_ctrl_model i_ctrl (.mclk(mclk), .want_hi(want_hi), .want_lo(want_lo),
        .want_sch(want_sch), .high_side_input(high_side_input),
        .low_side_input(low_side_input), .scheme_select(scheme_select));
    initial begin
        forever #25 mclk = ~mclk;
    end
    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task drive(input logic [1:0] s, input logic [2:0] h, input logic [2:0] l);
        want_sch <= s;
        want_hi <= h;
        want_lo <= l;
        cyc(4);
    endtask
    function logic [5:0] dec(input logic [1:0] s, input logic [2:0] h, input logic [2:0] l);
        dec = 6'h0;
        for (int i = 0; i < 3; i++) begin
            if (s[1]) dec[2*i +: 2] = l[i] ? (h[i] ? 2'h1 : 2'h2) : 2'h0;
            else dec[2*i +: 2] = (h[i] ^ l[i]) ? (h[i] ? 2'h1 : 2'h2) : 2'h0;
        end
    endfunction
    task done(input string s);
        $display("Test %s finished", s);
    endtask
    task print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        num_errors++;
        $display("Error %0t: run did not finish", $time);
        print_verdict;
    end
    initial begin
        cyc(8);
        resetn <= 1;
        cyc(4);
        `CHK(serial_ready, 1'b0)
        for (int s = 0; s < 4; s += 2) begin
            for (int v = 0; v < 16; v++) begin
                drive(s[1:0], v[2:0], v[3:1]);
                `CHK(half_bridge_output, dec(s[1:0], v[2:0], v[3:1]))
            end
        end
        drive(2'h2, 3'h5, 3'h7);
        `CHK(half_bridge_output, 6'h19)
        done("decode");
        for (int s = 0; s < 4; s++) begin
            drive(s[1:0], 3'h0, 3'h0);
            `CHK(reference_or_limit_input, s[0])
            `CHK(sense_amp_output, ~s[0])
        end
        for (int k = 0; k < 2; k++) begin
            overcurrent_trip_level <= k[0];
            supply_high_guard_threshold <= k[0];
            cyc(3);
            `CHK(trip_level_high, k[0])
            `CHK(supply_high_level_low, k[0])
        end
        done("config");
        drive(2'h1, 3'h1, 3'h0);
        limit_compare_raw <= 1;
        cyc(60);
        `CHK(half_bridge_output[1:0], 2'h1)
        cyc(50);
        `CHK(half_bridge_output[1:0], 2'h0)
        limit_compare_raw <= 0;
        drive(2'h0, 3'h7, 3'h0);
        done("limit");
        for (int f = 0; f < 4; f++) begin
            overcurrent_filter_select <= f[1:0];
            overcurrent_restart_select <= f[0];
            overcurrent_raw <= 3'h2;
            cyc(ncyc[f] - 2);
            overcurrent_raw <= 3'h0;
            cyc(3);
            `CHK(fault_status[1], 1'b0)
            overcurrent_raw <= 3'h2;
            cyc(ncyc[f] + 4);
            `CHK(fault_status[1:0], 2'h3)
            `CHK(half_bridge_output, 6'h00)
            overcurrent_raw <= 3'h0;
            cyc(60);
            `CHK(fault_status[1], f[0])
            cyc(30);
            `CHK(half_bridge_output, 6'h15)
        end
        done("overcurrent");
        supply_low_raw <= 1;
        cyc(90);
        `CHK(fault_flag_n_oe, 1'b0)
        cyc(20);
        `CHK(fault_status[2], 1'b1)
        supply_low_raw <= 0;
        supply_high_raw <= 1;
        cyc(110);
        `CHK(fault_flag_n_oe, 1'b0)
        supply_high_raw <= 0;
        supply_high_guard_enable <= 1;
        cyc(5);
        supply_high_raw <= 1;
        cyc(90);
        `CHK(fault_status[3], 1'b0)
        cyc(20);
        `CHK(fault_status[3], 1'b1)
        supply_high_raw <= 0;
        done("supply");
        strap_variant <= 1;
        cyc(105);
        overcurrent_raw <= 3'h1;
        cyc(10);
        `CHK(fault_flag_n_oe, 1'b1)
        `CHK(fault_status, 4'h0)
        overcurrent_raw <= 3'h0;
        cyc(60);
        `CHK(fault_flag_n_oe, 1'b0)
        `CHK(serial_ready, 1'b1)
        done("strap");
        print_verdict;
    end
endmodule
